// ===== hw/tsicd_cfg.svh
// offsets, field positions, reset values and timing counts of the channel core
//------------------------------------------------------------
// Operation
//------------------------------------------------------------
`ifndef TSICD_CFG_SVH
`define TSICD_CFG_SVH
`define TSICD_SPACE_DM 2'h3
`define TSICD_SPACE_CM 2'h2
`define TSICD_SPACE_REG 2'h1
`define TSICD_REG_CR 3'h0
`define TSICD_REG_FAR 3'h1
`define TSICD_REG_FOR0 3'h2
`define TSICD_CR_RESET 16'h4000
`define TSICD_CR_RATE_LSB 0
`define TSICD_CR_FEVAL 4
`define TSICD_CR_STANDBY 5
`define TSICD_CR_BPSTART 6
`define TSICD_CR_BPD_LSB 7
`define TSICD_CR_BPMODE 10
`define TSICD_FAR_DONE 12
`define TSICD_FAR_FRAMES 2'h2
`define TSICD_CM_LOOP 15
`define TSICD_CM_MODE_LSB 13
`define TSICD_MODE_VAR 2'h0
`define TSICD_MODE_CONST 2'h1
`define TSICD_MODE_PROC 2'h2
`define TSICD_MODE_HIZ 2'h3
`define TSICD_PAGES 3
`define TSICD_BP_BOUND 260
`endif

// ===== hw/tsicd_pkg.sv
// types of the channel core
package tsicd_pkg;
  typedef logic [15:0] tsicd_word_t;
  typedef enum logic {TSICD_BP_IDLE, TSICD_BP_FILL} tsicd_bp_t;
endpackage : tsicd_pkg

// ===== hw/tsicd_core.sv
// per-channel switch core: memories, delay modes, output drive and host registers
`timescale 1ns/100ps
`include "tsicd_cfg.svh"
module tsicd_core import tsicd_pkg::*; #(
  parameter int STREAMS = 16,
  parameter int CHANS = 256,
  parameter int SLOT_DIV = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [13:0] adr_i,
  input wire logic [15:0] dat_i,
  output logic [15:0] dat_o,
  input wire logic we_i,
  input wire logic [1:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic framePulseIn,
  input wire logic outputDriveEnablePin,
  input wire logic [STREAMS*8-1:0] rxByte,
  output logic [STREAMS*8-1:0] txByte,
  output logic [STREAMS-1:0] txDriveEn,
  output logic [STREAMS-1:0] outEnableInd
);
  localparam int SW = $clog2(STREAMS);
  localparam int CW = $clog2(CHANS);
  localparam int AW = 2 + SW + CW;
  localparam int BP_BOUND = `TSICD_BP_BOUND;

  // refused at elaboration: address fields and the divider cannot serve other sizes
  if (STREAMS < 2 || STREAMS > 16 || (1 << SW) != STREAMS || CHANS < 8 || CHANS > 256 ||
      (1 << CW) != CHANS || SLOT_DIV < 1 || SLOT_DIV > 255) begin : g_bad_params
    $error("tsicd_core: unsupported STREAMS, CHANS or SLOT_DIV");
  end

  //------------------------------------------------------------
  // state
  //------------------------------------------------------------
  tsicd_word_t ctrl_q, ctrl_d;
  tsicd_word_t offs_q [4];
  tsicd_word_t offs_d [4];
  logic [CW-1:0] slot_q, slot_d;
  logic [1:0] page_q, page_d;
  logic [7:0] div_q, div_d;
  tsicd_bp_t bp_q, bp_d;
  logic [CW-1:0] bpIdx_q, bpIdx_d;
  logic ack_q, ack_d;
  logic [15:0] datO_q, datO_d;
  logic [STREAMS*8-1:0] tx_q, tx_d;
  logic [STREAMS-1:0] oe_q, oe_d;
  logic [1:0] feCnt_q, feCnt_d;
  logic feDone_q, feDone_d;

  tsicd_word_t cm [STREAMS*CHANS];
  logic [7:0] dm [4*STREAMS*CHANS];

  logic req, slotEn, allDrive;
  logic [1:0] space;
  logic [1:0] prevPage, oldPage;
  logic [STREAMS*8-1:0] txNext, rxEff;
  logic [STREAMS-1:0] chHiz;
  tsicd_word_t hostCm;
  logic [7:0] hostDm;

  function automatic tsicd_word_t merge(input tsicd_word_t old, input tsicd_word_t nw, input logic [1:0] sel);
    merge = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
  endfunction : merge

  assign req = cyc_i && stb_i && !ack_q;
  assign space = adr_i[13:12];
  assign slotEn = (div_q == 8'(SLOT_DIV - 1));
  assign prevPage = (page_q == 2'h0) ? 2'h2 : page_q - 2'h1;
  // frame n is read back two frames on, i.e. the page after the current one
  assign oldPage = (page_q == 2'h2) ? 2'h0 : page_q + 2'h1;
  assign allDrive = outputDriveEnablePin || ctrl_q[`TSICD_CR_STANDBY];
  assign hostCm = cm[{adr_i[8 +: SW], adr_i[0 +: CW]}];
  assign hostDm = dm[{page_q, adr_i[8 +: SW], adr_i[0 +: CW]}];

  //------------------------------------------------------------
  // per output stream switching
  //------------------------------------------------------------
  genvar s;
  for (s = 0; s < STREAMS; s++) begin : g_str
    tsicd_word_t word;
    logic [1:0] mode;
    logic [SW-1:0] srcS;
    logic [CW-1:0] srcC;
    logic [1:0] rdPage;
    assign word = cm[{SW'(s), slot_q}];
    assign mode = word[`TSICD_CM_MODE_LSB +: 2];
    assign srcS = word[8 +: SW];
    assign srcC = word[0 +: CW];
    // variable: a slot already written this frame comes from this frame's page
    assign rdPage = (mode == `TSICD_MODE_CONST) ? oldPage :
                    (srcC < slot_q) ? page_q : prevPage;
    assign txNext[s*8 +: 8] = (mode == `TSICD_MODE_PROC) ? word[7:0] :
                              dm[{rdPage, srcS, srcC}];
    assign rxEff[s*8 +: 8] = word[`TSICD_CM_LOOP] ? txNext[s*8 +: 8] : rxByte[s*8 +: 8];
    assign chHiz[s] = (mode == `TSICD_MODE_HIZ);

    a_proc_byte: assert property (@(posedge core_clk) disable iff (rst)
      slotEn && mode == `TSICD_MODE_PROC |=> txByte[s*8 +: 8] == $past(word[7:0]))
      else $error("processor channel byte not sent");
    a_chan_hiz: assert property (@(posedge core_clk) disable iff (rst)
      chHiz[s] |=> !txDriveEn[s] && !outEnableInd[s])
      else $error("high-impedance channel driven");
    a_drive_on: assert property (@(posedge core_clk) disable iff (rst)
      allDrive && !chHiz[s] |=> txDriveEn[s] && outEnableInd[s])
      else $error("enabled channel not driven");
    a_var_page: assert property (@(posedge core_clk) disable iff (rst)
      mode == `TSICD_MODE_VAR |-> rdPage != oldPage)
      else $error("variable delay read from oldest page");
    a_var_same: assert property (@(posedge core_clk) disable iff (rst)
      mode == `TSICD_MODE_VAR && (CW+1)'(srcC) + (CW+1)'(3) <= (CW+1)'(slot_q) |-> rdPage == page_q)
      else $error("variable delay byte not sent in same frame");
    a_const_page: assert property (@(posedge core_clk) disable iff (rst)
      mode == `TSICD_MODE_CONST |-> rdPage != page_q && rdPage != prevPage)
      else $error("constant delay page not two frames back");
  end

  //------------------------------------------------------------
  // memories: connection memory is never reset
  //------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (bp_q == TSICD_BP_FILL) begin
      for (int i = 0; i < STREAMS; i++) begin
        cm[{SW'(i), bpIdx_q}] <= {ctrl_q[`TSICD_CR_BPD_LSB +: 3], 13'h0000};
      end
    end else if (req && we_i && space == `TSICD_SPACE_CM) begin
      cm[{adr_i[8 +: SW], adr_i[0 +: CW]}] <= merge(hostCm, dat_i, sel_i);
    end
    if (slotEn) begin
      for (int i = 0; i < STREAMS; i++) begin
        dm[{page_q, SW'(i), slot_q}] <= rxEff[i*8 +: 8];
      end
    end
  end

  //------------------------------------------------------------
  // next state
  //------------------------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    offs_d = offs_q;
    slot_d = slot_q;
    page_d = page_q;
    div_d = slotEn ? 8'h00 : div_q + 8'h01;
    bp_d = bp_q;
    bpIdx_d = bpIdx_q;
    ack_d = req;
    datO_d = datO_q;
    tx_d = tx_q;
    feCnt_d = feCnt_q;
    feDone_d = feDone_q;
    if (framePulseIn) begin
      slot_d = '0;
      div_d = 8'h00;
      page_d = oldPage;
      if (ctrl_q[`TSICD_CR_FEVAL] && feCnt_q != `TSICD_FAR_FRAMES) begin
        feCnt_d = feCnt_q + 2'h1;
      end
      if (ctrl_q[`TSICD_CR_FEVAL] && feCnt_q == `TSICD_FAR_FRAMES - 2'h1) begin
        feDone_d = 1'b1;
      end
    end else if (slotEn) begin
      slot_d = slot_q + CW'(1);
    end
    if (!ctrl_q[`TSICD_CR_FEVAL]) begin
      feCnt_d = 2'h0;
      feDone_d = 1'b0;
    end
    if (slotEn) begin
      tx_d = txNext;
    end
    // block fill: one channel of every stream per cycle
    case (bp_q)
      TSICD_BP_IDLE: begin
        if (ctrl_q[`TSICD_CR_BPSTART] && ctrl_q[`TSICD_CR_BPMODE]) begin
          bp_d = TSICD_BP_FILL;
          bpIdx_d = '0;
        end
      end
      TSICD_BP_FILL: begin
        bpIdx_d = bpIdx_q + CW'(1);
        if (bpIdx_q == CW'(CHANS - 1)) begin
          bp_d = TSICD_BP_IDLE;
          ctrl_d[`TSICD_CR_BPSTART] = 1'b0;
        end
      end
      default: bp_d = TSICD_BP_IDLE;
    endcase
    // host access after the fill update, so a host control register write of the same cycle wins
    if (req) begin
      datO_d = 16'h0000;
      case (space)
        `TSICD_SPACE_DM: datO_d = {8'h00, hostDm};
        `TSICD_SPACE_CM: datO_d = we_i ? merge(hostCm, dat_i, sel_i) : hostCm;
        `TSICD_SPACE_REG: begin
          case (adr_i[11:9])
            `TSICD_REG_CR: begin
              if (we_i) begin
                ctrl_d = merge(ctrl_d, dat_i, sel_i);
              end
              datO_d = we_i ? merge(ctrl_d, dat_i, sel_i) : ctrl_q;
            end
            `TSICD_REG_FAR: datO_d = 16'(feDone_q) << `TSICD_FAR_DONE;
            default: begin
              if (adr_i[11:9] <= `TSICD_REG_FOR0 + 3'h3) begin
                if (we_i) begin
                  offs_d[2'(adr_i[11:9] - `TSICD_REG_FOR0)] = merge(offs_q[2'(adr_i[11:9] - `TSICD_REG_FOR0)],
                                                                     dat_i, sel_i);
                end
                datO_d = we_i ? offs_d[2'(adr_i[11:9] - `TSICD_REG_FOR0)]
                              : offs_q[2'(adr_i[11:9] - `TSICD_REG_FOR0)];
              end
            end
          endcase
        end
        default: datO_d = 16'h0000;
      endcase
    end
    for (int i = 0; i < STREAMS; i++) begin
      oe_d[i] = allDrive && !chHiz[i];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `TSICD_CR_RESET;
      offs_q <= '{default: 16'h0000};
      slot_q <= '0;
      page_q <= 2'h0;
      div_q <= 8'h00;
      bp_q <= TSICD_BP_IDLE;
      bpIdx_q <= '0;
      ack_q <= 1'b0;
      datO_q <= 16'h0000;
      tx_q <= '0;
      oe_q <= '0;
      feCnt_q <= 2'h0;
      feDone_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      offs_q <= offs_d;
      slot_q <= slot_d;
      page_q <= page_d;
      div_q <= div_d;
      bp_q <= bp_d;
      bpIdx_q <= bpIdx_d;
      ack_q <= ack_d;
      datO_q <= datO_d;
      tx_q <= tx_d;
      oe_q <= oe_d;
      feCnt_q <= feCnt_d;
      feDone_q <= feDone_d;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = datO_q;
  assign txByte = tx_q;
  assign txDriveEn = oe_q;
  assign outEnableInd = oe_q;

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  sequence s_fill_start;
    bp_q == TSICD_BP_IDLE && ctrl_q[`TSICD_CR_BPSTART] && ctrl_q[`TSICD_CR_BPMODE];
  endsequence
  sequence s_fill_end;
    ##[1:BP_BOUND] (bp_q == TSICD_BP_IDLE && !ctrl_q[`TSICD_CR_BPSTART]);
  endsequence

  a_bus_single: assert property (@(posedge core_clk) disable iff (rst)
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("host access not answered in one cycle");
  a_fill_done: assert property (@(posedge core_clk) disable iff (rst)
    s_fill_start ##1 (!(req && we_i && space == `TSICD_SPACE_REG)) [*1] |-> s_fill_end)
    else $error("block fill did not finish and clear start");
  a_fill_gated: assert property (@(posedge core_clk) disable iff (rst)
    bp_q == TSICD_BP_IDLE && !ctrl_q[`TSICD_CR_BPMODE] |=> bp_q == TSICD_BP_IDLE)
    else $error("block fill began without mode bit");
  a_all_hiz: assert property (@(posedge core_clk) disable iff (rst)
    !outputDriveEnablePin && !ctrl_q[`TSICD_CR_STANDBY] |=> txDriveEn == '0)
    else $error("outputs driven with pin and standby low");
  a_reset_state: assert property (@(posedge core_clk)
    $fell(rst) |-> ctrl_q == `TSICD_CR_RESET && txDriveEn == '0)
    else $error("reset defaults not restored");
  a_dm_read: assert property (@(posedge core_clk) disable iff (rst)
    req && !we_i && space == `TSICD_SPACE_DM |=> dat_o[15:8] == 8'h00 && dat_o[7:0] == $past(hostDm))
    else $error("data memory read wrong");
  a_frame_start: assert property (@(posedge core_clk) disable iff (rst)
    framePulseIn |=> slot_q == '0 && page_q != $past(page_q))
    else $error("frame pulse did not restart slots");
  a_loop_feed: assert property (@(posedge core_clk) disable iff (rst)
    slotEn && cm[{SW'(0), slot_q}][`TSICD_CM_LOOP] |-> rxEff[7:0] == txNext[7:0])
    else $error("loopback byte not fed back");
  a_fill_word: assert property (@(posedge core_clk) disable iff (rst)
    bp_q == TSICD_BP_FILL |=> cm[{SW'(0), $past(bpIdx_q)}] == {$past(ctrl_q[`TSICD_CR_BPD_LSB +: 3]), 13'h0000})
    else $error("block fill word wrong");
  a_cr_write: assert property (@(posedge core_clk) disable iff (rst)
    req && we_i && sel_i == 2'h3 && space == `TSICD_SPACE_REG && adr_i[11:9] == `TSICD_REG_CR
    |=> ctrl_q == $past(dat_i))
    else $error("control register write lost");
endmodule : tsicd_core

// ===== verif/tsicd_stream_src.sv
// stream source model: frame pulse and per-stream receive bytes
`timescale 1ns/100ps
module tsicd_stream_src #(
  parameter int FRAME = 32
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [127:0] pat,
  output logic framePulseIn,
  output logic [127:0] rxByte
);
  int cnt;
  // ------------------------------------------------------------
  // frame timing
  // ------------------------------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      framePulseIn <= 1'b0;
      rxByte <= 128'h0;
    end else begin
      cnt <= (cnt == FRAME - 1) ? 0 : cnt + 1;
      framePulseIn <= (cnt == 0);
      // bytes held steady so every slot of a frame carries a known value
      rxByte <= pat;
    end
  end
endmodule : tsicd_stream_src

// ===== verif/tsicd_core_bench.sv
// self-checking bench of the channel core: host bus tasks, stream source, drive checks
`timescale 1ns/100ps
module tsicd_core_bench import tsicd_pkg::*; ;
  localparam int CH = 16;
  localparam int SD = 2;
  localparam int FR = CH * SD;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic pin = 1'b0;
  logic [13:0] adr = 14'h0;
  tsicd_word_t dat = 16'h0;
  tsicd_word_t datO;
  tsicd_word_t wd;
  logic ack;
  logic framePulseIn;
  logic [127:0] pat = 128'h0;
  logic [127:0] rxByte;
  logic [127:0] txByte;
  logic [15:0] txDriveEn;
  logic [15:0] ind;
  logic [7:0] b;
  logic [3:0] s;
  logic [3:0] c;
  int on;
  int oth;
  bit seen;
  tsicd_word_t expQ[$];
  int mismatches = 0;
  int cmp_count = 0;

  always #5 core_clk = ~core_clk;

  tsicd_core #(.STREAMS(16), .CHANS(CH), .SLOT_DIV(SD)) u_tsicd_core (.core_clk(core_clk), .rst(rst),
    .adr_i(adr), .dat_i(dat), .dat_o(datO), .we_i(we), .sel_i(2'h3), .cyc_i(cyc), .stb_i(stb), .ack_o(ack),
    .framePulseIn(framePulseIn), .outputDriveEnablePin(pin), .rxByte(rxByte), .txByte(txByte),
    .txDriveEn(txDriveEn), .outEnableInd(ind));
  tsicd_stream_src #(.FRAME(FR)) u_tsicd_stream_src (.core_clk(core_clk), .rst(rst), .pat(pat),
    .framePulseIn(framePulseIn), .rxByte(rxByte));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [13:0] a, input tsicd_word_t d);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge core_clk);
    while (ack !== 1'b1) @(posedge core_clk);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic rd(input logic [13:0] a, input tsicd_word_t e);
    expQ.push_back(e);
    wb(1'b0, a, 16'h0);
  endtask : rd

  // four whole frames, so the driven-slot count is exact
  task automatic watch(input int st, input logic [7:0] eb);
    on = 0;
    oth = 0;
    seen = 0;
    repeat (4 * FR) begin
      @(posedge core_clk);
      if (txDriveEn[st] === 1'b1) on++;
      if ((txDriveEn & ~(16'h1 << st)) !== 16'h0) oth++;
      // the byte only counts while its channel is actually driven
      if (txDriveEn[st] === 1'b1 && txByte[st*8 +: 8] === eb) seen = 1'b1;
    end
  endtask : watch

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report

  // ------------------------------------------------------------
  // output monitor
  // ------------------------------------------------------------
  always @(posedge core_clk) begin
    if (ack === 1'b1 && we === 1'b0) chk("host read", expQ.pop_front(), datO);
    if (rst === 1'b0) chk("indication", txDriveEn, ind);
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    $display("watchdog expired");
    final_report();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h529e));
    pat = {$urandom(), $urandom(), $urandom(), $urandom()};
    repeat (20) @(posedge core_clk);
    chk("drive in reset", 16'h0, txDriveEn);
    rst <= 1'b0;
    rd(14'h1000, 16'h4000);
    wb(1'b1, 14'h1000, 16'h4000);
    wb(1'b1, 14'h1200, 16'hffff);
    rd(14'h1200, 16'h0);
    rd(14'h1c00, 16'h0);
    for (int i = 0; i < 4; i++) begin
      s = 4'($urandom());
      c = 4'($urandom());
      wd = 16'($urandom());
      wb(1'b1, {2'b10, s, 4'h0, c}, wd);
      rd({2'b10, s, 4'h0, c}, wd);
    end
    $display("test registers done");
    wb(1'b1, 14'h2101, 16'h1234);
    wb(1'b1, 14'h1000, 16'h42c0);
    repeat (CH + 4) @(posedge core_clk);
    rd(14'h2101, 16'h1234);
    wb(1'b1, 14'h1000, 16'h45c0);
    repeat (CH + 4) @(posedge core_clk);
    rd(14'h1000, 16'h4580);
    rd(14'h2101, 16'h6000);
    rd(14'h2f0f, 16'h6000);
    $display("test block fill done");
    s = 4'($urandom());
    rd({2'b11, s, 8'h07}, {8'h0, pat[s*8 +: 8]});
    @(posedge core_clk);
    pin <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      b = 8'($urandom());
      s = 4'($urandom());
      wd = (m == 2) ? {3'b010, 5'h0, b} : {1'b0, 2'(m), 1'b0, s, 8'h05};
      wb(1'b1, 14'h2304, wd);
      watch(3, (m == 2) ? b : pat[s*8 +: 8]);
      chk("driven slots", 16'(4 * SD), 16'(on));
      chk("other streams", 16'h0, 16'(oth));
      chk("byte seen", 16'h1, {15'h0, seen});
    end
    wb(1'b1, 14'h2304, 16'h6000);
    watch(3, 8'h0);
    chk("hiz channel", 16'h0, 16'(on));
    wb(1'b1, 14'h2304, 16'h40a5);
    @(posedge core_clk);
    pin <= 1'b0;
    // drive enable is registered: let the last cycle with the pin high pass
    @(posedge core_clk);
    watch(3, 8'ha5);
    chk("pin and standby low", 16'h0, 16'(on));
    wb(1'b1, 14'h1000, 16'h4020);
    watch(3, 8'ha5);
    chk("standby high", 16'(4 * SD), 16'(on));
    chk("standby byte", 16'h1, {15'h0, seen});
    $display("test output drive done");
    wd = 16'($urandom());
    wb(1'b1, 14'h1a00, wd);
    rd(14'h1a00, wd);
    for (int r = 2; r < 6; r++) begin
      wb(1'b1, {2'b01, 3'(r), 9'h000}, 16'h0);
    end
    wb(1'b1, 14'h1000, 16'h4030);
    b = 8'($urandom());
    wb(1'b1, 14'h2304, {8'hc0, b});
    watch(3, b);
    chk("loop channel driven", 16'(4 * SD), 16'(on));
    chk("loop byte sent", 16'h1, {15'h0, seen});
    rd({2'b11, 4'h3, 8'h04}, {8'h0, b});
    rd(14'h1200, 16'h1000);
    $display("test loopback done");
    final_report();
  end
endmodule : tsicd_core_bench
